/* common/flash_id_pkg.sv */
package flash_id_pkg;

  localparam int                ADDR_W               = 16;
  localparam int                DATA_W               = 16;

  // Word offsets
  localparam logic [15:0]       DEVICE_IDENTIFICATION_OFFSET     = 16'hF001;
  localparam logic [15:0]       VERSION_IDENTIFICATION_OFFSET    = 16'hF002;
  localparam logic [15:0]       DATA_BUF_OFFSET      = 16'hF003;
  localparam logic [15:0]       BOOT_BUF_OFFSET      = 16'hF004;
  localparam logic [15:0]       BUF_COUNT_OFFSET     = 16'hF005;
  localparam logic [15:0]       ARRAY_CELL_TYPE_OFFSET          = 16'hF006;
  localparam logic [15:0]       BLOCK_SEL_OFFSET     = 16'hF100;
  localparam logic [15:0]       DIE_BUF_OFFSET       = 16'hF101;
  localparam logic [15:0]       CB_BLOCK_OFFSET      = 16'hF102;
  localparam logic [15:0]       CB_PAGE_OFFSET       = 16'hF103;
  localparam logic [15:0]       RSVD_FIVE_OFFSET     = 16'hF104;
  localparam logic [15:0]       RSVD_SIX_OFFSET      = 16'hF105;

  // Identification field positions
  localparam int                SUPPLY_LSB           = 0;
  localparam int                BUS_STYLE_BIT        = 2;
  localparam int                DIE_COUNT_BIT        = 3;
  localparam int                DENSITY_LSB          = 4;

  localparam logic [1:0]        SUPPLY_1V8           = 2'h0;
  localparam logic [1:0]        SUPPLY_3V3           = 2'h1;
  localparam logic [2:0]        DENSITY_128M         = 3'h0;
  localparam logic [2:0]        DENSITY_256M         = 3'h1;
  localparam logic [2:0]        DENSITY_512M         = 3'h2;
  localparam logic [2:0]        DENSITY_1G           = 3'h3;
  localparam logic [2:0]        DENSITY_2G           = 3'h4;
  localparam logic [2:0]        DENSITY_4G           = 3'h5;

  // Fixed read-only values and the reset value of the writable registers
  localparam logic [15:0]       DATA_BUF_WORDS_VAL   = 16'h0800;
  localparam logic [15:0]       BOOT_BUF_WORDS_VAL   = 16'h0200;
  localparam logic [15:0]       BUF_COUNT_VAL        = 16'h0201;
  localparam logic [15:0]       ARRAY_CELL_TYPE_SLC_VAL         = 16'h0000;
  localparam logic [15:0]       ARRAY_CELL_TYPE_MLC_VAL         = 16'h0001;
  localparam logic [15:0]       RW_RESET_VAL         = 16'h0000;

  // Field positions of writable registers
  localparam int                BLOCK_INDEX_W        = 10;
  localparam int                DIE_SELECT_BIT       = 15;
  localparam int                CB_PAGE_LSB          = 2;
  localparam int                CB_PAGE_W            = 6;
  localparam int                CB_SECTOR_W          = 2;

  typedef struct packed {
    logic                       rd;
    logic                       wr;
    logic [ADDR_W-1:0]          addr;
    logic [DATA_W-1:0]          wdata;
  } host_req_type;

  typedef struct packed {
    logic                       core_die_select;
    logic [BLOCK_INDEX_W-1:0]   flash_block_index;
    logic                       buffer_die_select;
    logic [BLOCK_INDEX_W-1:0]   copyback_block_index;
    logic [CB_PAGE_W-1:0]       copyback_page_index;
    logic [CB_SECTOR_W-1:0]     copyback_sector_index;
  } start_addr_type;

endpackage

/* rtl/flash_identity_address_regs.sv */
// Overview of operation
// - Identity bits 1:0 give supply class, 00 for 1.8V, 01 for 2.65/3.3V.
// - Identity bit 2 marks demultiplexed bus, bit 3 marks a dual-die package.
// - Identity bits 6:4 encode density, 000 for 128Mb up to 101 for 4Gb.
// - Data buffer size reads 0800h, two buffers of 1024 words.
// - Boot buffer size reads 0200h, one 512-word buffer.
// - Buffer count reads 0201h: two data buffers, one boot buffer.
// - Array technology reads 0000h for SLC; 0001h would mean MLC.
// - Block select bits 9:0 hold the flash block index.
// - Block select bit 15 picks the core die, top bit of a 2048-block index.
// - Die buffer select has one writable top bit; others read zero.
// - Copy-back block register holds destination block in bits 9:0.
// - Copy-back page in bits 7:2, sector in bits 1:0, both reset zero.
// - All writable start-address registers reset to 0000h.
// - Fifth and sixth start-address locations are reserved, no function.
// - Version identification location is reserved, no host function.
module flash_identity_address_regs
  import flash_id_pkg::*;
#(
  parameter logic [1:0]         SUPPLY_CLASS    = SUPPLY_1V8,
  parameter logic               DEMUX_BUS       = 1'b0,
  parameter logic               DUAL_DIE        = 1'b0,
  parameter logic [2:0]         DENSITY_CODE    = DENSITY_1G,
  parameter logic               MLC_ARRAY       = 1'b0
)
(
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RESET_N_IN,
  input  wire logic              CLK_EN_IN,
  input  wire logic              RD_IN,
  input  wire logic              WR_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  output logic      [DATA_W-1:0] RDATA_OUT,
  output logic                   RVALID_OUT,
  output start_addr_type         START_ADDR_OUT
);

  // One flag per decoded word; the else-if chain keeps them exclusive
  typedef struct packed {
    logic                       device_identification;
    logic                       version_identification;
    logic                       data_buf;
    logic                       boot_buf;
    logic                       buf_count;
    logic                       array_cell_type;
    logic                       block_sel;
    logic                       die_buf;
    logic                       cb_block;
    logic                       cb_page;
    logic                       rsvd_five;
    logic                       rsvd_six;
  } hit_type;

  typedef struct packed {
    logic                       block_sel;
    logic                       die_buf;
    logic                       cb_block;
    logic                       cb_page;
  } wr_strobe_type;

  typedef struct packed {
    start_addr_type             addr;
    logic [DATA_W-1:0]          rdata;
    logic                       rvalid;
  } state_type;

  localparam int                ADDR_STATE_W    = $bits(start_addr_type);

  state_type                    state_reg;
  state_type                    state_next;
  host_req_type                 req;
  hit_type                      hit;
  wr_strobe_type                wr_strobe;
  start_addr_type               wr_fields;
  logic [DATA_W-1:0]            identity_word;
  logic [DATA_W-1:0]            raw_word;
  logic [DATA_W-1:0]            read_mask;
  wire logic [DATA_W-1:0]       read_word;

  assign req = '{rd: RD_IN, wr: WR_IN, addr: ADDR_IN, wdata: WDATA_IN};

  always_comb
  begin
    hit = '0;
    if (req.addr == DEVICE_IDENTIFICATION_OFFSET)
    begin
      hit.device_identification = 1'b1;
    end
    else if (req.addr == VERSION_IDENTIFICATION_OFFSET)
    begin
      hit.version_identification = 1'b1;
    end
    else if (req.addr == DATA_BUF_OFFSET)
    begin
      hit.data_buf = 1'b1;
    end
    else if (req.addr == BOOT_BUF_OFFSET)
    begin
      hit.boot_buf = 1'b1;
    end
    else if (req.addr == BUF_COUNT_OFFSET)
    begin
      hit.buf_count = 1'b1;
    end
    else if (req.addr == ARRAY_CELL_TYPE_OFFSET)
    begin
      hit.array_cell_type = 1'b1;
    end
    else if (req.addr == BLOCK_SEL_OFFSET)
    begin
      hit.block_sel = 1'b1;
    end
    else if (req.addr == DIE_BUF_OFFSET)
    begin
      hit.die_buf = 1'b1;
    end
    else if (req.addr == CB_BLOCK_OFFSET)
    begin
      hit.cb_block = 1'b1;
    end
    else if (req.addr == CB_PAGE_OFFSET)
    begin
      hit.cb_page = 1'b1;
    end
    else if (req.addr == RSVD_FIVE_OFFSET)
    begin
      hit.rsvd_five = 1'b1;
    end
    else if (req.addr == RSVD_SIX_OFFSET)
    begin
      hit.rsvd_six = 1'b1;
    end
  end

  always_comb
  begin
    identity_word = '0;
    identity_word[SUPPLY_LSB +: 2] = SUPPLY_CLASS;
    identity_word[BUS_STYLE_BIT] = DEMUX_BUS;
    identity_word[DIE_COUNT_BIT] = DUAL_DIE;
    identity_word[DENSITY_LSB +: 3] = DENSITY_CODE;
  end

  always_comb
  begin
    raw_word = '0;
    if (hit.device_identification)
    begin
      raw_word = identity_word;
    end
    else if (hit.version_identification)
    begin
      raw_word = '0;
    end
    else if (hit.data_buf)
    begin
      raw_word = DATA_BUF_WORDS_VAL;
    end
    else if (hit.boot_buf)
    begin
      raw_word = BOOT_BUF_WORDS_VAL;
    end
    else if (hit.buf_count)
    begin
      raw_word = BUF_COUNT_VAL;
    end
    else if (hit.array_cell_type)
    begin
      if (MLC_ARRAY)
      begin
        raw_word = ARRAY_CELL_TYPE_MLC_VAL;
      end
      else
      begin
        raw_word = ARRAY_CELL_TYPE_SLC_VAL;
      end
    end
    else if (hit.block_sel)
    begin
      raw_word[DIE_SELECT_BIT] = state_reg.addr.core_die_select;
      raw_word[BLOCK_INDEX_W-1:0] = state_reg.addr.flash_block_index;
    end
    else if (hit.die_buf)
    begin
      raw_word[DIE_SELECT_BIT] = state_reg.addr.buffer_die_select;
    end
    else if (hit.cb_block)
    begin
      raw_word[BLOCK_INDEX_W-1:0] = state_reg.addr.copyback_block_index;
    end
    else if (hit.cb_page)
    begin
      raw_word[CB_PAGE_LSB +: CB_PAGE_W] = state_reg.addr.copyback_page_index;
      raw_word[CB_SECTOR_W-1:0] = state_reg.addr.copyback_sector_index;
    end
    else if (hit.rsvd_five)
    begin
      raw_word = '0;
    end
    else if (hit.rsvd_six)
    begin
      raw_word = '0;
    end
  end

  // Readable bits per word, so a stray field bit can never leak into a reserved position
  always_comb
  begin
    read_mask = '0;
    if (hit.device_identification)
    begin
      read_mask = '1;
    end
    else if (hit.data_buf)
    begin
      read_mask = '1;
    end
    else if (hit.boot_buf)
    begin
      read_mask = '1;
    end
    else if (hit.buf_count)
    begin
      read_mask = '1;
    end
    else if (hit.array_cell_type)
    begin
      read_mask = '1;
    end
    else if (hit.block_sel)
    begin
      read_mask[DIE_SELECT_BIT] = 1'b1;
      read_mask[BLOCK_INDEX_W-1:0] = '1;
    end
    else if (hit.die_buf)
    begin
      read_mask[DIE_SELECT_BIT] = 1'b1;
    end
    else if (hit.cb_block)
    begin
      read_mask[BLOCK_INDEX_W-1:0] = '1;
    end
    else if (hit.cb_page)
    begin
      read_mask[CB_PAGE_LSB +: CB_PAGE_W] = '1;
      read_mask[CB_SECTOR_W-1:0] = '1;
    end
    else if (hit.version_identification)
    begin
      read_mask = '0;
    end
    else if (hit.rsvd_five)
    begin
      read_mask = '0;
    end
    else if (hit.rsvd_six)
    begin
      read_mask = '0;
    end
  end

  generate
    for (genvar bit_idx = 0; bit_idx < DATA_W; bit_idx++)
    begin : gen_read_bit
      assign read_word[bit_idx] = raw_word[bit_idx] & read_mask[bit_idx];
    end
  endgenerate

  // Writes to anything but these four words never reach state
  always_comb
  begin
    wr_strobe = '0;
    if (req.wr)
    begin
      wr_strobe.block_sel = hit.block_sel;
      wr_strobe.die_buf = hit.die_buf;
      wr_strobe.cb_block = hit.cb_block;
      wr_strobe.cb_page = hit.cb_page;
    end
  end

  always_comb
  begin
    wr_fields = '0;
    wr_fields.core_die_select = req.wdata[DIE_SELECT_BIT];
    wr_fields.flash_block_index = req.wdata[BLOCK_INDEX_W-1:0];
    wr_fields.buffer_die_select = req.wdata[DIE_SELECT_BIT];
    wr_fields.copyback_block_index = req.wdata[BLOCK_INDEX_W-1:0];
    wr_fields.copyback_page_index = req.wdata[CB_PAGE_LSB +: CB_PAGE_W];
    wr_fields.copyback_sector_index = req.wdata[CB_SECTOR_W-1:0];
  end

  // Read and write in one cycle return the old word; the write lands behind it
  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = req.rd;
    if (req.rd)
    begin
      state_next.rdata = read_word;
    end
    if (wr_strobe.block_sel)
    begin
      state_next.addr.core_die_select = wr_fields.core_die_select;
      state_next.addr.flash_block_index = wr_fields.flash_block_index;
    end
    if (wr_strobe.die_buf)
    begin
      state_next.addr.buffer_die_select = wr_fields.buffer_die_select;
    end
    if (wr_strobe.cb_block)
    begin
      state_next.addr.copyback_block_index = wr_fields.copyback_block_index;
    end
    if (wr_strobe.cb_page)
    begin
      state_next.addr.copyback_page_index = wr_fields.copyback_page_index;
      state_next.addr.copyback_sector_index = wr_fields.copyback_sector_index;
    end
  end

  // Reset ignores the enable so a frozen block still comes out clean
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RESET_N_IN)
    begin
      state_reg.addr <= start_addr_type'(ADDR_STATE_W'(RW_RESET_VAL));
      state_reg.rdata <= '0;
      state_reg.rvalid <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      state_reg <= state_next;
    end
  end

  assign RDATA_OUT = state_reg.rdata;
  assign RVALID_OUT = state_reg.rvalid;
  assign START_ADDR_OUT = state_reg.addr;

endmodule // flash_identity_address_regs

/* verif/flash_regs_chk_sva.sv */
module flash_regs_chk
  import flash_id_pkg::*;
(
  input wire logic              CLK_SYS_IN,
  input wire logic              RESET_N_IN,
  input wire logic              CLK_EN_IN,
  input wire logic              RD_IN,
  input wire logic              WR_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic [DATA_W-1:0] RDATA_OUT,
  input wire logic              RVALID_OUT,
  input wire start_addr_type    START_ADDR_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic rd = RD_IN && CLK_EN_IN;
  wire logic wr = WR_IN && CLK_EN_IN;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  // Identity word assumes the default parameter set
  property p_id; rd && ADDR_IN == 16'hF001 |=> RVALID_OUT && RDATA_OUT == 16'h0030; endproperty
  a_id: assert property (p_id) else $error("identity word wrong");
  property p_dbuf; rd && ADDR_IN == 16'hF003 |=> RDATA_OUT == 16'h0800; endproperty
  a_dbuf: assert property (p_dbuf) else $error("data buffer size wrong");
  property p_bbuf; rd && ADDR_IN == 16'hF004 |=> RDATA_OUT == 16'h0200; endproperty
  a_bbuf: assert property (p_bbuf) else $error("boot buffer size wrong");
  property p_cnt; rd && ADDR_IN == 16'hF005 |=> RDATA_OUT == 16'h0201; endproperty
  a_cnt: assert property (p_cnt) else $error("buffer count wrong");
  property p_array_cell_type; rd && ADDR_IN == 16'hF006 |=> RDATA_OUT == 16'h0000; endproperty
  a_array_cell_type: assert property (p_array_cell_type) else $error("array type wrong");
  property p_rsvd; rd && ADDR_IN inside {16'hF002, 16'hF104, 16'hF105} |=> RDATA_OUT == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
  property p_blk; wr && ADDR_IN == 16'hF100 |=> {START_ADDR_OUT.core_die_select,
    START_ADDR_OUT.flash_block_index} == {$past(WDATA_IN[15]), $past(WDATA_IN[9:0])}; endproperty
  a_blk: assert property (p_blk) else $error("block select not stored");
  property p_cb; wr && ADDR_IN == 16'hF103 |=> {START_ADDR_OUT.copyback_page_index,
    START_ADDR_OUT.copyback_sector_index} == $past(WDATA_IN[7:0]); endproperty
  a_cb: assert property (p_cb) else $error("page and sector not stored");
  property p_dbs; wr && ADDR_IN == 16'hF101 |=>
    START_ADDR_OUT.buffer_die_select == $past(WDATA_IN[15]); endproperty
  a_dbs: assert property (p_dbs) else $error("buffer die select not stored");
  property p_cbb; wr && ADDR_IN == 16'hF102 |=>
    START_ADDR_OUT.copyback_block_index == $past(WDATA_IN[9:0]); endproperty
  a_cbb: assert property (p_cbb) else $error("copy-back block not stored");
  property p_hold; !(wr && ADDR_IN[15:2] == 14'h3C40) |=> $stable(START_ADDR_OUT); endproperty
  a_hold: assert property (p_hold) else $error("start address moved without write");
endmodule // flash_regs_chk

bind flash_identity_address_regs flash_regs_chk chk (.CLK_SYS_IN, .RESET_N_IN, .CLK_EN_IN, .RD_IN, .WR_IN,
  .ADDR_IN, .WDATA_IN, .RDATA_OUT, .RVALID_OUT, .START_ADDR_OUT);

/* verif/host_model.sv */
module host_model
  import flash_id_pkg::*;
(
  input  wire logic   clk_in,
  output host_req_type req_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus shows inverted values so stale data never passes
  initial req_out = '{1'b0, 1'b0, 16'h5A5A, 16'hA5A5};
  task automatic xfer(input logic r, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req_out <= '{r, !r, a, d};
    @(posedge clk_in);
    req_out <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // host_model

/* verif/testbench.sv */
module testbench
  import flash_id_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] addr, wdata, exp;} row_type;
  logic           clk;
  logic           rst_n;
  logic           clk_en;
  logic [15:0]    rdata;
  logic           rvalid;
  host_req_type   req;
  start_addr_type start_addr;
  int             miscompares = 0;
  int             num_checks = 0;
  row_type rows [13] = '{'{16'hF001, 16'hFFFF, 16'h0030}, '{16'hF002, 16'hFFFF, 16'h0000},
    '{16'hF003, 16'h0000, 16'h0800}, '{16'hF004, 16'h0000, 16'h0200}, '{16'hF005, 16'h0000, 16'h0201},
    '{16'hF006, 16'hFFFF, 16'h0000}, '{16'hF100, 16'h8155, 16'h8155}, '{16'hF101, 16'hFFFF, 16'h8000},
    '{16'hF102, 16'hFFFF, 16'h03FF}, '{16'hF103, 16'hFFFF, 16'h00FF}, '{16'hF104, 16'hFFFF, 16'h0000},
    '{16'hF105, 16'hFFFF, 16'h0000}, '{16'hF0FF, 16'hFFFF, 16'h0000}};
  host_model host (.clk_in(clk), .req_out(req));
  flash_identity_address_regs uut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .CLK_EN_IN(clk_en), .RD_IN(req.rd),
    .WR_IN(req.wr), .ADDR_IN(req.addr), .WDATA_IN(req.wdata), .RDATA_OUT(rdata), .RVALID_OUT(rvalid),
    .START_ADDR_OUT(start_addr));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    host.xfer(1'b1, a, 16'h0000);
    #1;
    check(32'({rvalid, rdata}), 32'({1'b1, e}));
    // Valid drops after one cycle while the word stays put
    @(posedge clk);
    #1;
    check(32'({rvalid, rdata}), 32'({1'b0, e}));
  endtask
  task automatic do_reset;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(32'(start_addr), '0);
  endtask
  task automatic close_out;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    do_reset();
    foreach (rows[i])
    begin
      host.xfer(1'b0, rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    check(32'(start_addr), 32'({1'b1, 10'h155, 1'b1, 10'h3FF, 6'h3F, 2'h3}));
    $display("register table test done");
    @(posedge clk) clk_en <= 1'b0;
    // Frozen cycle must drop the write
    host.xfer(1'b0, 16'hF102, 16'h0000);
    @(posedge clk) clk_en <= 1'b1;
    rd_chk(16'hF102, 16'h03FF);
    $display("clock enable test done");
    @(posedge clk) rst_n <= 1'b0;
    do_reset();
    rd_chk(16'hF100, 16'h0000);
    $display("second reset test done");
    close_out();
  end
endmodule // testbench
